// File: logic/polarity_detect_defines.svh
`ifndef POLARITY_DETECT_DEFINES_SVH
`define POLARITY_DETECT_DEFINES_SVH

// ****************************************
// Configuration encodings
// ****************************************
`define SENSOR_CFG_W          4
`define SENSOR_CFG_USE_SENSOR 4'h0
`define SENSOR_CFG_NO_SENSOR  4'h1
`define TEST_CFG_W            4
`define TEST_CFG_DISABLED     4'h0

// ****************************************
// Timing
// ****************************************
`define CLOCK_FREQ_HZ         100000000
// Longest polarity detection run before it counts as failed, in ms
`define DETECT_TIMEOUT_MS     2000
`define DETECT_TIMEOUT_CYCLES ((`CLOCK_FREQ_HZ / 1000) * `DETECT_TIMEOUT_MS)

`endif

// File: logic/polarity_detect_pkg.sv
package polarity_detect_pkg;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'b00001,
      ST_DETECT  = 5'b00010,
      ST_READY   = 5'b00100,
      ST_FAILED  = 5'b01000,
      ST_RUN     = 5'b10000
   } seq_e;

endpackage

// File: logic/linear_motor_polarity_detect.sv
// Functional notes
// [RULE1] Without polarity sensor, detect polarity before controlling the motor.
// [RULE2] Without polarity sensor, refuse servo on until detection succeeded.
// [RULE3] Incremental encoder: polarity lost at power off, detect after each power-up.
// [RULE4] Absolute encoder: polarity kept in encoder across control power cycles.
// [RULE5] Start detection only when sensor config says no polarity sensor.
// [RULE6] Start detection only while the servo is off.
// [RULE7] Start detection only while main circuit power is on.
// [RULE8] Start detection only while no hardwired gate block is active.
// [RULE9] Any alarm blocks detection except the phase info mismatch alarm.
// [RULE10] Test-without-motor mode blocks detection.
// [RULE11] Any overtravel blocks detection.
// [RULE12] After motor parameter write or origin set, require power cycle first.
// [RULE13] Servo-on triggers detection only with an incremental encoder.
// [RULE14] After power-up, servo-on runs detection, then servo-ready asserts.
// [RULE15] Servo-on closed enables servo and motor power; open disables it.
// [RULE16] Request rising edge turns servo on, detects once, stays on, ready.
// [RULE17] Only first request rising edge after power-up triggers detection.
// [RULE18] Request input is inactive unless allocated to an input pin.
// [RULE19] Request configured always active starts detection at main power on.
// [RULE20] Utility command also starts detection, for both encoder types.
// [RULE21] Sensor config 0 uses sensor, 1 none; change takes effect after restart.
// [RULE22] On failure leave servo off, ready low, and raise error flag.
`timescale 1ns/1ps
`default_nettype none
`include "polarity_detect_defines.svh"

module linear_motor_polarity_detect #(
   parameter int unsigned DETECT_TIMEOUT_CYCLES = `DETECT_TIMEOUT_CYCLES
) (
   input  wire logic                     I_CLOCK,
   input  wire logic                     I_SYS_RST,
   input  wire logic [`SENSOR_CFG_W-1:0] i_motor_sensor_config,
   input  wire logic [`TEST_CFG_W-1:0]   i_test_mode_config,
   input  wire logic                     i_absolute_encoder,
   input  wire logic                     i_polarity_stored,
   input  wire logic                     i_servo_on,
   input  wire logic                     i_polarity_detect_request,
   input  wire logic                     i_request_allocated,
   input  wire logic                     i_request_always_active,
   input  wire logic                     i_polarity_detect_utility,
   input  wire logic                     i_main_power_on,
   input  wire logic                     i_hardwired_gate_block,
   input  wire logic                     i_alarm_active,
   input  wire logic                     i_phase_info_mismatch_alarm,
   input  wire logic                     i_overtravel,
   input  wire logic                     i_param_written,
   input  wire logic                     i_detect_done,
   input  wire logic                     i_detect_fail,
   output logic                          o_detect_start,
   output logic                          o_detect_busy,
   output logic                          o_servo_enable,
   output logic                          o_servo_ready,
   output logic                          o_polarity_valid,
   output logic                          o_store_polarity,
   output logic                          o_detect_error,
   output logic                          o_restart_needed
);

   typedef struct packed {
      polarity_detect_pkg::seq_e state;
      logic                      no_sensor;
      logic                      restart_needed;
      logic                      polarity_valid;
      logic                      request_prev;
      logic                      request_used;
      logic                      main_prev;
      logic                      via_request;
      logic [31:0]               timer;
      logic                      detect_start;
      logic                      store_polarity;
      logic                      detect_error;
      logic                      captured;
   } state_s;

   state_s cur;
   state_s next_cur;

   // ****************************************
   // Helpers
   // ****************************************
   // Detection finished or not needed: servo may be offered to the host
   function automatic logic operating(input polarity_detect_pkg::seq_e st);
      return (st == polarity_detect_pkg::ST_READY) || (st == polarity_detect_pkg::ST_RUN);
   endfunction

   // Motor is powered by the detection run itself
   function automatic logic detecting(input polarity_detect_pkg::seq_e st);
      return (st == polarity_detect_pkg::ST_DETECT);
   endfunction

   // Interlocks checked before a start and watched during a run
   function automatic logic interlocks_ok(
      input logic main_on,
      input logic gate_block,
      input logic alarm_block,
      input logic overtravel
   );
      return main_on && !gate_block && !alarm_block && !overtravel;
   endfunction

   // Mismatch alarm only says the angle is unknown; detection resolves it
   function automatic logic blocking_alarm(
      input logic any_alarm,
      input logic mismatch
   );
      return any_alarm && !mismatch;
   endfunction

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      logic request_level;
      logic request_rise;
      logic main_rise;
      logic alarm_blocks;
      logic start_ok;
      logic trig_son;
      logic trig_req;
      logic trig_util;
      logic interlock;
      logic test_off;
      request_level = 1'b0;
      request_rise  = 1'b0;
      main_rise     = 1'b0;
      alarm_blocks  = 1'b0;
      start_ok      = 1'b0;
      trig_son      = 1'b0;
      trig_req      = 1'b0;
      trig_util     = 1'b0;
      interlock     = 1'b0;
      test_off      = 1'b0;
      next_cur = cur;
      next_cur.detect_start   = 1'b0;
      next_cur.store_polarity = 1'b0;

      // ****************************************
      // Config capture
      // ****************************************
      // [RULE21] Config sampled once after restart
      if (!cur.captured) begin
         next_cur.captured  = 1'b1;
         next_cur.no_sensor = (i_motor_sensor_config == `SENSOR_CFG_NO_SENSOR);
         // [RULE4] Stored polarity survives power cycle
         next_cur.polarity_valid = i_absolute_encoder && i_polarity_stored;
      end

      // ****************************************
      // Restart latch
      // ****************************************
      // [RULE12] Parameter write demands power cycle
      if (i_param_written) begin
         next_cur.restart_needed = 1'b1;
      end

      // [RULE18] Unallocated request stays inactive
      request_level = i_request_allocated &&
                      (i_polarity_detect_request || i_request_always_active);
      request_rise  = request_level && !cur.request_prev;
      main_rise     = i_main_power_on && !cur.main_prev;
      next_cur.request_prev = request_level;
      // [RULE19] Held low until config is in, so power on at power-up still counts
      if (cur.captured) begin
         next_cur.main_prev = i_main_power_on;
      end

      // ****************************************
      // Start interlocks
      // ****************************************
      // [RULE9] Mismatch alarm alone does not block
      alarm_blocks = blocking_alarm(i_alarm_active, i_phase_info_mismatch_alarm);
      // [RULE7] [RULE8] [RULE11] Same interlocks abort a running detection
      interlock    = interlocks_ok(i_main_power_on, i_hardwired_gate_block, alarm_blocks,
                                   i_overtravel);
      // [RULE10] Test-without-motor mode blocks a detection start
      test_off     = (i_test_mode_config == `TEST_CFG_DISABLED);
      // [RULE5] [RULE6] Start only from idle, where the servo is always off
      start_ok     = cur.captured && cur.no_sensor && !cur.polarity_valid &&
                     interlock && test_off &&
                     !cur.restart_needed && !i_param_written;

      // ****************************************
      // Triggers
      // ****************************************
      // [RULE13] Servo-on trigger only with incremental encoder
      trig_son  = i_servo_on && !i_absolute_encoder;
      // [RULE17] [RULE19] First edge only; always-active fires at main power on
      trig_req  = !cur.request_used &&
                  (request_rise || (request_level && i_request_always_active && main_rise));
      // [RULE20] Utility for either encoder
      trig_util = i_polarity_detect_utility;

      // ****************************************
      // Sequencer states
      // ****************************************
      case (cur.state)
         polarity_detect_pkg::ST_IDLE: begin
            if (cur.captured && (!cur.no_sensor || cur.polarity_valid)) begin
               next_cur.state = polarity_detect_pkg::ST_RUN;
            end else if (start_ok && (trig_son || trig_req || trig_util)) begin
               // [RULE1] [RULE14] [RULE16] Launch detection
               next_cur.state        = polarity_detect_pkg::ST_DETECT;
               next_cur.detect_start = 1'b1;
               next_cur.via_request  = trig_req;
               next_cur.detect_error = 1'b0;
               next_cur.timer        = 32'h0;
               if (trig_req) begin
                  next_cur.request_used = 1'b1;
               end
            end
         end
         polarity_detect_pkg::ST_DETECT: begin
            next_cur.timer = cur.timer + 32'h1;
            if (i_detect_done) begin
               next_cur.polarity_valid = 1'b1;
               // [RULE4] Write result back to absolute encoder
               next_cur.store_polarity = i_absolute_encoder;
               next_cur.state          = polarity_detect_pkg::ST_READY;
            // Motor is powered here, so a lost interlock must abort at once
            end else if (i_detect_fail || cur.timer >= DETECT_TIMEOUT_CYCLES - 1 ||
                         !interlock) begin
               // [RULE22] Failure leaves servo off
               next_cur.detect_error = 1'b1;
               next_cur.state        = polarity_detect_pkg::ST_FAILED;
            end
         end
         polarity_detect_pkg::ST_READY: begin
            next_cur.state = polarity_detect_pkg::ST_RUN;
         end
         polarity_detect_pkg::ST_FAILED: begin
            // Retry needs a fresh trigger with servo-on released
            if (!i_servo_on && !i_polarity_detect_utility) begin
               next_cur.state = polarity_detect_pkg::ST_IDLE;
            end
         end
         polarity_detect_pkg::ST_RUN: begin
            next_cur.state = polarity_detect_pkg::ST_RUN;
         end
         default: begin
            next_cur.state = polarity_detect_pkg::ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   // [RULE3] Synchronous reset is the control power-up
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         cur <= '{state: polarity_detect_pkg::ST_IDLE, timer: 32'h0, default: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         o_detect_start   <= 1'b0;
         o_detect_busy    <= 1'b0;
         o_servo_enable   <= 1'b0;
         o_servo_ready    <= 1'b0;
         o_polarity_valid <= 1'b0;
         o_store_polarity <= 1'b0;
         o_detect_error   <= 1'b0;
         o_restart_needed <= 1'b0;
      end else begin
         o_detect_start   <= next_cur.detect_start;
         o_detect_busy    <= detecting(next_cur.state);
         // [RULE2] [RULE15] [RULE16] Servo power gated by sequencer state: detecting or operating
         // Gate block cuts power at once, whatever the sequencer holds
         o_servo_enable   <= detecting(next_cur.state) ||
                             (operating(next_cur.state) &&
                              (i_servo_on || next_cur.via_request) &&
                              !i_hardwired_gate_block);
         // [RULE14] Ready as soon as detection completes
         o_servo_ready    <= operating(next_cur.state) &&
                             i_main_power_on && !i_hardwired_gate_block;
         o_polarity_valid <= next_cur.polarity_valid;
         o_store_polarity <= next_cur.store_polarity;
         o_detect_error   <= next_cur.detect_error;
         o_restart_needed <= next_cur.restart_needed;
      end
   end

endmodule

`default_nettype wire

// File: bench/polarity_detect_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "polarity_detect_defines.svh"
module polarity_detect_monitor (
   input wire logic                   I_CLOCK,
   input wire logic                   I_SYS_RST,
   input wire logic [`TEST_CFG_W-1:0] i_test_mode_config,
   input wire logic                   i_absolute_encoder,
   input wire logic                   i_main_power_on,
   input wire logic                   i_hardwired_gate_block,
   input wire logic                   i_alarm_active,
   input wire logic                   i_phase_info_mismatch_alarm,
   input wire logic                   i_overtravel,
   input wire logic                   i_detect_done,
   input wire logic                   i_detect_fail,
   input wire logic                   o_detect_start,
   input wire logic                   o_detect_busy,
   input wire logic                   o_servo_enable,
   input wire logic                   o_servo_ready,
   input wire logic                   o_polarity_valid,
   input wire logic                   o_store_polarity,
   input wire logic                   o_detect_error
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   AST_START_PULSE: assert property (
      o_detect_start |=> !o_detect_start)
      else $error("start pulse longer than one cycle");
   AST_START_BUSY: assert property (
      o_detect_start |-> o_detect_busy && o_servo_enable)
      else $error("start without busy and servo enable");
   AST_PRECOND: assert property (
      o_detect_start |-> $past(i_main_power_on && !i_hardwired_gate_block && !i_overtravel))
      else $error("start while power, gate block or overtravel forbid it");
   AST_TEST_MODE: assert property (
      o_detect_start |-> $past(i_test_mode_config) == `TEST_CFG_DISABLED)
      else $error("start in test mode");
   AST_ALARM: assert property (
      o_detect_start |-> $past(!i_alarm_active || i_phase_info_mismatch_alarm))
      else $error("start under a blocking alarm");
   AST_SERVO_OFF: assert property (
      o_detect_start |-> !$past(o_servo_enable))
      else $error("start while servo was on");
   AST_DONE: assert property (
      o_detect_busy && i_detect_done && !i_detect_fail |=>
      o_servo_ready && o_polarity_valid && !o_detect_busy)
      else $error("no ready after detection done");
   AST_FAIL: assert property (
      o_detect_busy && i_detect_fail |=>
      o_detect_error && !o_servo_enable && !o_servo_ready)
      else $error("failure not reported");
   AST_ONCE: assert property (
      o_polarity_valid |-> !o_detect_start)
      else $error("detection restarted after success");
   AST_STORE: assert property (
      o_detect_busy && i_detect_done && i_absolute_encoder |=> o_store_polarity)
      else $error("polarity not stored to absolute encoder");
   COV_START: cover property (o_detect_start);
   COV_READY: cover property ($rose(o_servo_ready));
   COV_ERROR: cover property ($rose(o_detect_error));
endmodule
bind linear_motor_polarity_detect polarity_detect_monitor u_mon (.*);
`default_nettype wire

// File: bench/polarity_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Detection engine: answers each start after a chosen delay
module polarity_engine_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   input  wire logic       i_fail,
   input  wire logic [4:0] i_delay,
   output logic            o_done,
   output logic            o_fail
);
   logic [5:0] cnt;
   always_ff @(posedge i_clock) begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      if (i_rst) begin
         cnt <= 6'h00;
      end else if (i_start) begin
         cnt <= {1'b0, i_delay} + 6'h01;
      end else if (cnt != 6'h00) begin
         cnt <= cnt - 6'h01;
         o_done <= (cnt == 6'h01) && !i_fail;
         o_fail <= (cnt == 6'h01) && i_fail;
      end
   end
endmodule
`default_nettype wire

// File: bench/test_linear_motor_polarity_detect.sv
`timescale 1ns/1ps
`default_nettype none
module test_linear_motor_polarity_detect;
   logic       I_CLOCK = 1'b0, I_SYS_RST = 1'b1, eng_fail, s, p;
   logic [3:0] i_motor_sensor_config, i_test_mode_config;
   logic       i_absolute_encoder, i_polarity_stored, i_servo_on, i_polarity_detect_request;
   logic       i_request_allocated, i_request_always_active, i_polarity_detect_utility;
   logic       i_main_power_on, i_hardwired_gate_block, i_alarm_active, i_overtravel;
   logic       i_phase_info_mismatch_alarm, i_param_written, i_detect_done, i_detect_fail;
   logic       o_detect_start, o_detect_busy, o_servo_enable, o_servo_ready;
   logic       o_polarity_valid, o_store_polarity, o_detect_error, o_restart_needed;
   logic [4:0] dly;
   int         seed = 32'hcc93, n_fail = 0, num_checks = 0, cyc = 0;
   linear_motor_polarity_detect #(.DETECT_TIMEOUT_CYCLES(50)) uut (.*);
   polarity_engine_model eng (.i_clock(I_CLOCK), .i_rst(I_SYS_RST), .i_start(o_detect_start),
      .i_fail(eng_fail), .i_delay(dly), .o_done(i_detect_done), .o_fail(i_detect_fail));
   initial forever #5 I_CLOCK = ~I_CLOCK;
   always @(posedge I_CLOCK) begin
      cyc++;
      if (cyc > 10000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic rst(input logic [3:0] cfg, input logic ab, input logic pwr);
      I_SYS_RST = 1'b1;
      {i_test_mode_config, i_polarity_stored, i_servo_on, i_polarity_detect_request,
       i_request_allocated, i_request_always_active, i_polarity_detect_utility,
       i_hardwired_gate_block, i_alarm_active, i_phase_info_mismatch_alarm, i_overtravel,
       i_param_written, eng_fail} = '0;
      i_main_power_on = pwr;
      i_motor_sensor_config = cfg;
      i_absolute_encoder = ab;
      dly = 5'($random(seed));
      repeat (10) @(negedge I_CLOCK);
      I_SYS_RST = 1'b0;
      repeat (2) @(negedge I_CLOCK);
   endtask
   // Watch for a start and a store pulse, ending on a falling edge
   task automatic go(output logic seen, output logic st);
      seen = 1'b0;
      st = 1'b0;
      repeat (80) begin
         @(posedge I_CLOCK);
         #1 seen = seen | (o_detect_start === 1'b1);
         st = st | (o_store_polarity === 1'b1);
      end
      @(negedge I_CLOCK);
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rst(4'h1, 1'b0, 1'b1);
      for (int k = 0; k < 8; k++) begin
         rst(4'h1, 1'b0, 1'b1);
         case (k)
            0: i_hardwired_gate_block = 1'b1;
            1: i_alarm_active = 1'b1;
            2: i_overtravel = 1'b1;
            3: i_test_mode_config = 4'($random(seed)) | 4'h1;
            4: i_main_power_on = 1'b0;
            5: i_param_written = 1'b1;
            6: {i_alarm_active, i_phase_info_mismatch_alarm} = 2'b11;
            default: i_polarity_detect_request = 1'b1;
         endcase
         i_polarity_detect_utility = (k != 7);
         go(s, p);
         chk("guard", s, k == 6);
         chk("restart flag", o_restart_needed, k == 5);
      end
      $display("guard table finished");
      rst(4'h1, 1'b0, 1'b1);
      chk("valid after power-up", o_polarity_valid, 1'b0);
      i_servo_on = 1'b1;
      go(s, p);
      chk("servo-on start", s, 1'b1);
      chk("ready", o_servo_ready, 1'b1);
      chk("enable", o_servo_enable, 1'b1);
      i_servo_on = 1'b0;
      i_request_allocated = 1'b1;
      repeat (3) @(negedge I_CLOCK);
      chk("enable off", o_servo_enable, 1'b0);
      i_polarity_detect_request = 1'b1;
      go(s, p);
      chk("request after success", s, 1'b0);
      $display("servo-on trigger finished");
      rst(4'h1, 1'b1, 1'b1);
      i_servo_on = 1'b1;
      go(s, p);
      chk("servo-on absolute", s, 1'b0);
      chk("enable refused", o_servo_enable, 1'b0);
      i_servo_on = 1'b0;
      i_polarity_detect_utility = 1'b1;
      go(s, p);
      chk("utility start", s, 1'b1);
      chk("store pulse", p, 1'b1);
      rst(4'h1, 1'b1, 1'b1);
      i_polarity_stored = 1'b1;
      // Mid-run power cycle so the stored polarity is read back
      I_SYS_RST = 1'b1;
      @(negedge I_CLOCK);
      I_SYS_RST = 1'b0;
      repeat (2) @(negedge I_CLOCK);
      chk("stored polarity valid", o_polarity_valid, 1'b1);
      i_polarity_detect_utility = 1'b1;
      go(s, p);
      chk("stored polarity start", s, 1'b0);
      chk("stored polarity ready", o_servo_ready, 1'b1);
      $display("absolute encoder finished");
      rst(4'h1, 1'b0, 1'b1);
      eng_fail = 1'b1;
      i_polarity_detect_utility = 1'b1;
      go(s, p);
      chk("error", o_detect_error, 1'b1);
      chk("ready on failure", o_servo_ready, 1'b0);
      chk("enable on failure", o_servo_enable, 1'b0);
      i_polarity_detect_utility = 1'b0;
      eng_fail = 1'b0;
      @(negedge I_CLOCK);
      i_polarity_detect_utility = 1'b1;
      go(s, p);
      chk("retry start", s, 1'b1);
      chk("error cleared", o_detect_error, 1'b0);
      $display("failure and retry finished");
      rst(4'h1, 1'b0, 1'b1);
      i_request_allocated = 1'b1;
      i_polarity_detect_request = 1'b1;
      go(s, p);
      chk("request start", s, 1'b1);
      chk("request keeps servo", o_servo_enable, 1'b1);
      chk("request ready", o_servo_ready, 1'b1);
      rst(4'h1, 1'b0, 1'b0);
      {i_request_allocated, i_request_always_active} = 2'b11;
      repeat (3) @(negedge I_CLOCK);
      i_main_power_on = 1'b1;
      go(s, p);
      chk("always active start", s, 1'b1);
      rst(4'h0, 1'b0, 1'b1);
      i_polarity_detect_utility = 1'b1;
      go(s, p);
      chk("sensor present start", s, 1'b0);
      chk("sensor present ready", o_servo_ready, 1'b1);
      $display("request and sensor cases finished");
      complete_run();
   end
endmodule
`default_nettype wire
